// [core/msem_det_if.sv]
`timescale 1ns/1ns
interface msem_det_if;
	import msem_pkg::*;
	logic listen;
	logic clear;
	logic take;
	logic enable;
	logic pending;
	logic [3:0] flags;
	logic [ADDR_W-1:0] addr;
	modport mon (output listen, output clear, output take, output enable,
		input pending, input flags, input addr);
	modport mem (input listen, input clear, input take, input enable,
		output pending, output flags, output addr);
endinterface : msem_det_if

// [core/msem_mem_detect.sv]
`timescale 1ns/1ns
module msem_mem_detect
	import msem_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_rd_valid,
	input wire logic i_cor_err,
	input wire logic i_unc_err,
	input wire logic [ADDR_W-1:0] i_addr,
	msem_det_if.mem bus
);
	typedef struct packed {
		logic [3:0] flags;
		logic [ADDR_W-1:0] addr;
	} msem_det_st_t;
	msem_det_st_t r;
	msem_det_st_t next_r;

	always_comb
	begin
		next_r = r;
		if (bus.clear || bus.take)
			next_r = '0; // RQ10
		if (bus.enable && i_rd_valid) // RQ18 RQ2
		begin
			if (i_unc_err)
			begin
				if (bus.listen && !next_r.flags[FLAG_ERR]) // RQ17 RQ16
				begin
					next_r.flags[FLAG_ERR] = 1'b1; // RQ12
					next_r.addr = i_addr;
				end
				else
					next_r.flags[FLAG_ERR_OVF] = 1'b1; // RQ13
			end
			if (i_cor_err)
			begin
				if (bus.listen && !i_unc_err && next_r.flags[FLAG_ERR:FLAG_COR] == 3'h0)
				begin
					next_r.flags[FLAG_COR] = 1'b1; // RQ14
					next_r.addr = i_addr;
				end
				else
					next_r.flags[FLAG_COR_OVF] = 1'b1; // RQ15
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n)
			r <= '0;
		else
			r <= next_r;

	assign bus.pending = bus.enable && (r.flags != 4'h0);
	assign bus.flags = r.flags; // RQ11
	assign bus.addr = r.addr;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	AST_ADDR_ONLY_LISTEN: assert property ( // RQ17
		!bus.listen && !bus.clear && !bus.take |=> $stable(r.addr))
		else $error("Upset address changed outside scanning.");
	AST_UNC_KEEPS_ADDR: assert property ( // RQ16
		r.flags[FLAG_ERR] && !bus.clear && !bus.take |=> $stable(r.addr) && r.flags[FLAG_ERR])
		else $error("Uncorrectable upset address was overwritten.");
endmodule : msem_mem_detect

// [core/msem_monitor.sv]
//Contract
//[RQ1] After reset the monitor sits quiet until software asks to move.
//[RQ2] While quiet, memories keep indications locally and forward nothing.
//[RQ3] While scanning, pending indications set a status flag.
//[RQ4] In readout, flags, upset address and memory index are readable.
//[RQ5] Quiet, readout and scanning each have their own status bit.
//[RQ6] Step request reads set until the next state is reached, then clears.
//[RQ7] A busy bit stays set while a transition is under way.
//[RQ8] First request after reset clears all memories and goes to scanning.
//[RQ9] Software collects by going quiet then stepping until scanning again.
//[RQ10] Each memory holds one indication, cleared once read out.
//[RQ11] An indication is four flags and one upset address.
//[RQ12] Uncorrectable upset with captured address sets the uncorrectable flag.
//[RQ13] Uncorrectable upset without captured address sets uncorrectable overflow.
//[RQ14] Correctable upset with captured address sets the correctable flag.
//[RQ15] Correctable upset without captured address sets correctable overflow.
//[RQ16] Uncorrectable upsets take priority over correctable ones.
//[RQ17] Addresses are captured only while scanning; otherwise only overflow flags.
//[RQ18] Indications are raised when memory contents are read.
//[RQ19] Software raises the monitor speed before the first request.
//[RQ20] Host-interface memories are monitored only when software enables them.
//[RQ21] Index 181 is the classifier action memory, address equals row.
//[RQ22] From quiet or readout, step to next pending indication or scanning.
//[RQ23] From scanning step to quiet; busy drops as the status bit rises.
`timescale 1ns/1ns
module msem_monitor
	import msem_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [NUM_MEM-1:0] I_MEM_RD_VALID,
	input wire logic [NUM_MEM-1:0] I_CORRECTABLE_FLAG_ERR,
	input wire logic [NUM_MEM-1:0] I_MEM_UNC_ERR,
	input wire logic [NUM_MEM*ADDR_W-1:0] I_MEM_ADDR,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		msem_state_t state;
		logic [PTR_W-1:0] ptr;
		logic first_done;
		logic step_req;
		logic [DIV_W-1:0] speed;
		logic hostif_en;
		logic [3:0] info_flags;
		logic [ADDR_W-1:0] info_addr;
		logic [IDX_W-1:0] info_idx;
		logic indication;
		logic clear;
		logic [NUM_MEM-1:0] take;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} msem_mon_st_t;

	msem_mon_st_t r;
	msem_mon_st_t next_r;
	logic tick;
	logic busy;
	logic acc;
	logic wr;
	logic wr_ctrl;
	logic mapped;
	logic any_pending;
	logic [NUM_MEM-1:0] pending;
	logic [3:0] mem_flags [NUM_MEM];
	logic [ADDR_W-1:0] mem_addr [NUM_MEM];
	logic [31:0] rdata;

	// ------------------------------------------------------------
	// Protected memories
	// ------------------------------------------------------------
	generate
		for (genvar g = 0; g < NUM_MEM; g++)
		begin : g_mem
			msem_det_if dif ();
			assign dif.listen = (r.state == ST_SCANNING); // RQ17
			assign dif.clear = r.clear;
			assign dif.take = r.take[g];
			assign dif.enable = (g == HOSTIF_SLOT) ? r.hostif_en : 1'b1; // RQ20
			assign pending[g] = dif.pending;
			assign mem_flags[g] = dif.flags;
			assign mem_addr[g] = dif.addr;
			msem_mem_detect u_det (
				.i_clk(I_CLK_SYS),
				.i_rst_n(I_RST_N),
				.i_rd_valid(I_MEM_RD_VALID[g]),
				.i_cor_err(I_CORRECTABLE_FLAG_ERR[g]),
				.i_unc_err(I_MEM_UNC_ERR[g]),
				.i_addr(I_MEM_ADDR[g*ADDR_W +: ADDR_W]),
				.bus(dif.mem)
			);
		end
	endgenerate

	assign any_pending = |pending;
	assign busy = (r.state == ST_CLEAR) || (r.state == ST_SEARCH) || (r.state == ST_TO_QUIET);

	msem_tick_div u_div (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RST_N),
		.i_run(busy),
		.i_div(r.speed),
		.o_tick(tick)
	);

	// ------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------
	assign acc = I_PSEL && I_PENABLE && !r.pready;
	assign wr = I_PSEL && I_PENABLE && r.pready && I_PWRITE && !r.pslverr;
	assign wr_ctrl = wr && (I_PADDR == OFS_CTRL);
	assign mapped = (I_PADDR == OFS_CTRL) || (I_PADDR == OFS_STAT) ||
		(I_PADDR == OFS_INFO) || (I_PADDR == OFS_IDX) ||
		(I_PADDR == OFS_SPEED) || (I_PADDR == OFS_CFG);

	always_comb
	begin
		rdata = 32'h0000_0000;
		case (I_PADDR)
			OFS_CTRL: rdata[CTRL_STEP_BIT] = r.step_req; // RQ6
			OFS_STAT:
			begin
				rdata[STAT_QUIET_BIT] = (r.state == ST_QUIET); // RQ5
				rdata[STAT_READOUT_BIT] = (r.state == ST_READOUT);
				rdata[STAT_SCAN_BIT] = (r.state == ST_SCANNING);
				rdata[STAT_BUSY_BIT] = busy; // RQ7
				rdata[STAT_IND_BIT] = r.indication; // RQ3
			end
			OFS_INFO:
			begin
				rdata[INFO_FLAG_LSB +: 4] = r.info_flags; // RQ4 RQ11
				rdata[ADDR_W-1:0] = r.info_addr; // RQ21
			end
			OFS_IDX: rdata[IDX_W-1:0] = r.info_idx; // RQ4
			OFS_SPEED: rdata[DIV_W-1:0] = r.speed;
			OFS_CFG: rdata[CFG_HOSTIF_BIT] = r.hostif_en;
			default: rdata = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_r = r;
		next_r.clear = 1'b0;
		next_r.take = '0;
		next_r.pready = acc;
		if (acc)
		begin
			next_r.pslverr = !mapped;
			next_r.prdata = I_PWRITE ? 32'h0000_0000 : rdata;
		end
		else if (r.pready)
		begin
			next_r.pslverr = 1'b0;
			next_r.prdata = 32'h0000_0000;
		end
		if (r.state == ST_SCANNING && any_pending)
			next_r.indication = 1'b1; // RQ3 RQ2
		case (r.state)
			ST_QUIET:
				if (r.step_req) // RQ1
				begin
					next_r.ptr = '0;
					if (!r.first_done)
					begin
						next_r.first_done = 1'b1;
						next_r.clear = 1'b1; // RQ8
						next_r.indication = 1'b0;
						next_r.state = ST_CLEAR;
					end
					else
						next_r.state = ST_SEARCH; // RQ22
				end
			ST_SCANNING:
				if (r.step_req)
					next_r.state = ST_TO_QUIET; // RQ23
			ST_READOUT:
				if (r.step_req)
				begin
					if (r.ptr == PTR_W'(NUM_MEM - 1))
					begin
						next_r.state = ST_SCANNING; // RQ22
						next_r.step_req = 1'b0; // RQ6
					end
					else
					begin
						next_r.ptr = r.ptr + 2'h1;
						next_r.state = ST_SEARCH; // RQ22
					end
				end
			ST_CLEAR:
				if (tick)
				begin
					next_r.state = ST_SCANNING; // RQ8
					next_r.step_req = 1'b0; // RQ6
				end
			ST_TO_QUIET:
				if (tick)
				begin
					next_r.state = ST_QUIET; // RQ23
					next_r.step_req = 1'b0;
				end
			ST_SEARCH:
				if (tick)
				begin
					if (pending[r.ptr])
					begin
						next_r.info_flags = mem_flags[r.ptr]; // RQ4
						next_r.info_addr = mem_addr[r.ptr]; // RQ21
						next_r.info_idx = MEM_INDEX[r.ptr];
						next_r.take[r.ptr] = 1'b1; // RQ10
						next_r.state = ST_READOUT;
						next_r.step_req = 1'b0; // RQ6
					end
					else if (r.ptr == PTR_W'(NUM_MEM - 1))
					begin
						next_r.state = ST_SCANNING; // RQ22
						next_r.step_req = 1'b0;
					end
					else
						next_r.ptr = r.ptr + 2'h1;
				end
			default: next_r.state = ST_QUIET;
		endcase
		if (wr_ctrl && I_PWDATA[CTRL_STEP_BIT])
			next_r.step_req = 1'b1; // RQ6
		if (wr && I_PADDR == OFS_SPEED)
			next_r.speed = I_PWDATA[DIV_W-1:0]; // RQ19
		if (wr && I_PADDR == OFS_CFG)
			next_r.hostif_en = I_PWDATA[CFG_HOSTIF_BIT]; // RQ20
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
		if (!I_RST_N)
		begin
			r <= '0;
			r.state <= ST_QUIET; // RQ1
			r.speed <= SPEED_RST;
			r.hostif_en <= CFG_HOSTIF_RST;
		end
		else
			r <= next_r;

	assign O_PRDATA = r.prdata;
	assign O_PREADY = r.pready;
	assign O_PSLVERR = r.pslverr;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);

	sequence s_enter_readout;
		r.state == ST_READOUT && $past(r.state) == ST_SEARCH;
	endsequence

	sequence s_reached;
		$changed(r.state) && !busy && !$past(wr_ctrl);
	endsequence

	sequence s_search_hit;
		r.state == ST_SEARCH && tick && pending[r.ptr];
	endsequence

	AST_QUIET_HOLD: assert property ( // RQ1
		r.state == ST_QUIET && !r.step_req |=> r.state == ST_QUIET)
		else $error("Monitor left quiet without a request.");
	AST_QUIET_NO_FORWARD: assert property ( // RQ2
		r.state == ST_QUIET |=> $stable(r.indication))
		else $error("Indication forwarded while quiet.");
	AST_SCAN_FLAG: assert property ( // RQ3
		r.state == ST_SCANNING && any_pending |=> r.indication)
		else $error("Pending indication not flagged while scanning.");
	AST_READOUT_INFO: assert property ( // RQ4
		s_enter_readout |-> r.info_flags != 4'h0 && r.take != '0)
		else $error("Readout entered without a valid indication.");
	AST_REQ_HELD: assert property ( // RQ6
		busy |-> r.step_req)
		else $error("Step request dropped during a transition.");
	AST_REQ_CLEARED: assert property ( // RQ6
		s_reached |-> !r.step_req)
		else $error("Step request still set after state reached.");
	AST_FIRST_CLEAR: assert property ( // RQ8
		r.state == ST_QUIET && r.step_req && !r.first_done
		|=> r.state == ST_CLEAR && r.clear ##1 !r.clear)
		else $error("First request did not clear the memories.");
	AST_SCAN_TO_QUIET: assert property ( // RQ23
		r.state == ST_SCANNING && r.step_req |=> r.state == ST_TO_QUIET && busy)
		else $error("Scanning request did not head to quiet.");
	AST_TAKE_ONE: assert property ( // RQ10
		r.take != '0 |-> $onehot(r.take) ##1 r.take == '0)
		else $error("Read-out clear not a single pulse.");
	AST_CLEAR_TO_SCAN: assert property ( // RQ8
		r.state == ST_CLEAR && tick |=> r.state == ST_SCANNING)
		else $error("Clear step did not end in scanning.");
	AST_CLEAR_ONLY_FIRST: assert property ( // RQ8
		r.clear |-> !$past(r.first_done))
		else $error("Memories cleared on a later request.");
	AST_LATER_SEARCH: assert property ( // RQ22
		r.state == ST_QUIET && r.step_req && r.first_done |=> r.state == ST_SEARCH && r.ptr == '0)
		else $error("Later request did not start the search at memory zero.");
	AST_SEARCH_TAKE: assert property ( // RQ10
		s_search_hit |=> r.state == ST_READOUT && r.take[r.ptr])
		else $error("Search hit did not take the pending memory.");
	AST_SEARCH_END: assert property ( // RQ22
		r.state == ST_SEARCH && tick && !pending[r.ptr] && r.ptr == PTR_W'(NUM_MEM - 1)
		|=> r.state == ST_SCANNING)
		else $error("Search past the last memory did not return to scanning.");
	AST_READOUT_STEP: assert property ( // RQ22
		r.state == ST_READOUT && r.step_req |=> r.state inside {ST_SEARCH, ST_SCANNING})
		else $error("Readout request did not move on.");
	AST_INFO_STABLE: assert property ( // RQ4
		r.state == ST_READOUT
		|=> $stable(r.info_flags) && $stable(r.info_addr) && $stable(r.info_idx))
		else $error("Indication changed during readout.");
	AST_CLASSIFIER_IDX: assert property ( // RQ21
		r.state == ST_READOUT && $past(r.state) == ST_SEARCH && r.ptr == '0
		|-> r.info_idx == CLASSIFIER_IDX)
		else $error("First memory not reported with the classifier index.");
	AST_TAKE_IN_READOUT: assert property ( // RQ10
		r.take != '0 |-> s_enter_readout)
		else $error("Memory taken outside a readout entry.");
	AST_IND_STICKY: assert property ( // RQ3
		r.indication && !(r.state == ST_QUIET && r.step_req && !r.first_done) |=> r.indication)
		else $error("Indication flag dropped.");
	AST_TO_QUIET_DONE: assert property ( // RQ23
		r.state == ST_TO_QUIET && tick |=> r.state == ST_QUIET && !busy)
		else $error("Return to quiet did not complete.");
	AST_HOSTIF_MASK: assert property ( // RQ20
		!r.hostif_en |-> !pending[HOSTIF_SLOT])
		else $error("Disabled host-interface memory reported pending.");
endmodule : msem_monitor

// [core/msem_pkg.sv]
package msem_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int NUM_MEM = 4;
	localparam int ADDR_W = 16;
	localparam int IDX_W = 8;
	localparam int DIV_W = 16;
	localparam int PTR_W = 2;

	// ------------------------------------------------------------
	// Register offsets and fields
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_INFO = 8'h08;
	localparam logic [7:0] OFS_IDX = 8'h0c;
	localparam logic [7:0] OFS_SPEED = 8'h10;
	localparam logic [7:0] OFS_CFG = 8'h14;
	localparam int CTRL_STEP_BIT = 0;
	localparam int CFG_HOSTIF_BIT = 0;
	localparam int STAT_QUIET_BIT = 0;
	localparam int STAT_READOUT_BIT = 1;
	localparam int STAT_SCAN_BIT = 2;
	localparam int STAT_BUSY_BIT = 3;
	localparam int STAT_IND_BIT = 4;
	localparam int INFO_FLAG_LSB = 16;
	localparam int FLAG_COR_OVF = 0;
	localparam int FLAG_COR = 1;
	localparam int FLAG_ERR_OVF = 2;
	localparam int FLAG_ERR = 3;

	// ------------------------------------------------------------
	// Reset values and memory indexes
	// ------------------------------------------------------------
	localparam logic [DIV_W-1:0] SPEED_RST = 16'h00ff;
	localparam logic CFG_HOSTIF_RST = 1'b0;
	localparam int HOSTIF_SLOT = NUM_MEM - 1;
	localparam logic [IDX_W-1:0] CLASSIFIER_IDX = 8'hb5;
	localparam logic [IDX_W-1:0] MEM_INDEX [NUM_MEM] = '{CLASSIFIER_IDX, 8'hba, 8'hbb, 8'hbc};

	typedef enum logic [2:0] {
		ST_QUIET,
		ST_SCANNING,
		ST_READOUT,
		ST_CLEAR,
		ST_SEARCH,
		ST_TO_QUIET
	} msem_state_t;

endpackage : msem_pkg

// [core/msem_tick_div.sv]
`timescale 1ns/1ns
module msem_tick_div
	import msem_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire logic [DIV_W-1:0] i_div,
	output logic o_tick
);
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic tick;
	} msem_div_st_t;
	msem_div_st_t r;
	msem_div_st_t next_r;

	always_comb
	begin
		next_r = r;
		next_r.tick = i_run && (r.cnt >= i_div);
		if (!i_run || r.cnt >= i_div)
			next_r.cnt = '0;
		else
			next_r.cnt = r.cnt + 16'h0001;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n)
			r <= '0;
		else
			r <= next_r;

	assign o_tick = r.tick;
endmodule : msem_tick_div

// [verification/msem_mem_model.sv]
`timescale 1ns/1ns
// ------------------------------------------------------------
// Protected memory read model
// ------------------------------------------------------------
module msem_mem_model
	import msem_pkg::*;
(
	input wire logic i_clk,
	output logic [NUM_MEM-1:0] o_rd_valid,
	output logic [NUM_MEM-1:0] o_cor_err,
	output logic [NUM_MEM-1:0] o_unc_err,
	output logic [NUM_MEM*ADDR_W-1:0] o_addr
);
	initial
	begin
		o_rd_valid = '0;
		o_cor_err = '0;
		o_unc_err = '0;
		o_addr = '0;
	end

	// One read of memory m; outside the read the lines show the inverse.
	task automatic read_word(input int m, input logic cor, input logic unc,
		input logic [ADDR_W-1:0] a);
		@(posedge i_clk);
		o_rd_valid[m] <= 1'b1;
		o_cor_err[m] <= cor;
		o_unc_err[m] <= unc;
		o_addr[m*ADDR_W+:ADDR_W] <= a;
		@(posedge i_clk);
		o_rd_valid[m] <= 1'b0;
		o_cor_err[m] <= ~cor;
		o_unc_err[m] <= ~unc;
		o_addr[m*ADDR_W+:ADDR_W] <= ~a;
	endtask : read_word
endmodule : msem_mem_model

// [verification/msem_monitor_test.sv]
`timescale 1ns/1ns
module msem_monitor_test
	import msem_pkg::*;
;
	localparam int TMO = 20000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [NUM_MEM-1:0] rd_valid;
	logic [NUM_MEM-1:0] cor_err;
	logic [NUM_MEM-1:0] unc_err;
	logic [NUM_MEM*ADDR_W-1:0] mem_addr;
	logic [31:0] rd;
	logic er;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;

	msem_monitor uut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_MEM_RD_VALID(rd_valid),
		.I_CORRECTABLE_FLAG_ERR(cor_err), .I_MEM_UNC_ERR(unc_err), .I_MEM_ADDR(mem_addr),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr));

	msem_mem_model mem (.i_clk(clk), .o_rd_valid(rd_valid), .o_cor_err(cor_err),
		.o_unc_err(unc_err), .o_addr(mem_addr));

	initial
	begin
		forever #10 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
		checks++;
		if ((got & mask) !== (exp & mask))
		begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, mask);
	endtask : rdc

	task automatic step();
		int n;
		n = 0;
		apb(1'b1, OFS_CTRL, 32'h1);
		do
		begin
			apb(1'b0, OFS_CTRL, 32'h0);
			n++;
		end
		while (rd[CTRL_STEP_BIT] !== 1'b0 && n < 40);
		chk(rd, 32'h0, 32'h1);
	endtask : step

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == TMO)
		begin
			miscompares++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rdc(OFS_STAT, 32'h1, 32'h1f);
		chk({31'h0, er}, 32'h0, 32'h1);
		rdc(OFS_CTRL, 32'h0, 32'h1);
		rdc(OFS_SPEED, 32'h00ff, 32'hffff);
		rdc(OFS_CFG, 32'h0, 32'h1);
		apb(1'b0, 8'h18, 32'h0);
		chk({31'h0, er}, 32'h1, 32'h1);
		chk(rd, 32'h0, 32'hffffffff);
		apb(1'b1, OFS_STAT, 32'h1f);
		rdc(OFS_STAT, 32'h1, 32'h1f);
		apb(1'b1, OFS_SPEED, 32'h10);
		apb(1'b1, OFS_CTRL, 32'h1);
		rdc(OFS_STAT, 32'h8, 32'h8);
		rdc(OFS_CTRL, 32'h1, 32'h1);
		step();
		rdc(OFS_STAT, 32'h4, 32'hf);
		apb(1'b1, OFS_SPEED, 32'h3);
		mem.read_word(0, 1'b0, 1'b1, 16'h0012);
		mem.read_word(0, 1'b1, 1'b0, 16'h0034);
		mem.read_word(2, 1'b1, 1'b0, 16'h0056);
		mem.read_word(3, 1'b1, 1'b0, 16'h0077);
		rdc(OFS_STAT, 32'h14, 32'h1f);
		step();
		rdc(OFS_STAT, 32'h1, 32'hf);
		mem.read_word(1, 1'b0, 1'b1, 16'h0099);
		mem.read_word(1, 1'b1, 1'b0, 16'h00aa);
		step();
		rdc(OFS_STAT, 32'h2, 32'hf);
		rdc(OFS_INFO, 32'h0009_0012, 32'hffffffff);
		rdc(OFS_IDX, 32'hb5, 32'hff);
		step();
		rdc(OFS_STAT, 32'h2, 32'hf);
		rdc(OFS_INFO, 32'h0005_0000, 32'hffffffff);
		rdc(OFS_IDX, 32'hba, 32'hff);
		step();
		rdc(OFS_INFO, 32'h0002_0056, 32'hffffffff);
		rdc(OFS_IDX, 32'hbb, 32'hff);
		step();
		rdc(OFS_STAT, 32'h4, 32'hf);
		step();
		step();
		rdc(OFS_STAT, 32'h4, 32'hf);
		apb(1'b1, OFS_CFG, 32'h1);
		rdc(OFS_CFG, 32'h1, 32'h1);
		mem.read_word(3, 1'b1, 1'b0, 16'h0077);
		step();
		step();
		rdc(OFS_STAT, 32'h2, 32'hf);
		rdc(OFS_INFO, 32'h0002_0077, 32'hffffffff);
		rdc(OFS_IDX, 32'hbc, 32'hff);
		step();
		rdc(OFS_STAT, 32'h4, 32'hf);
		stop_test();
	end
endmodule : msem_monitor_test
